//--- rtl/gfr_pkg.sv
// gfr_pkg: constants and carrier types of the gesture fifo readout block.
// assumes one register access at a time from the serial bus engine.
package gfr_pkg;
  // register addresses as seen by the serial bus engine
  localparam logic [7:0] ADDR_COUNT = 8'hae; // dataset_count_reg
  localparam logic [7:0] ADDR_STATUS = 8'haf; // gesture_status
  localparam logic [7:0] ADDR_PB_CLR = 8'he3; // pattern_burst_irq_clear
  localparam logic [7:0] ADDR_FORCE = 8'he4; // force_interrupt
  localparam logic [7:0] ADDR_PX_CLR = 8'he5; // proximity_irq_clear
  localparam logic [7:0] ADDR_LT_CLR = 8'he6; // light_irq_clear
  localparam logic [7:0] ADDR_ALL_CLR = 8'he7; // all_nongesture_irq_clear
  localparam logic [7:0] ADDR_NORTH = 8'hfc; // fifo_north_data
  localparam logic [7:0] ADDR_SOUTH = 8'hfd; // fifo_south_data
  localparam logic [7:0] ADDR_WEST = 8'hfe; // fifo_west_data
  localparam logic [7:0] ADDR_EAST = 8'hff; // fifo_east_data
  // gesture_status field positions
  localparam int STAT_VALID_BIT = 0; // data_valid_flag
  localparam int STAT_OVF_BIT = 1; // fifo_overflow_flag
  // fifo geometry: 128 bytes as 32 datasets of four bytes
  localparam int FIFO_BYTES = 128;
  localparam int DATASET_BYTES = 4;
  localparam int FIFO_DEPTH = FIFO_BYTES / DATASET_BYTES;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_COUNT = 6'h00;
  localparam logic [4:0] RST_PTR = 5'h00;

  // one dataset as pushed by the gesture engine
  typedef struct packed {
    logic [7:0] north;
    logic [7:0] south;
    logic [7:0] west;
    logic [7:0] east;
  } gfr_dataset_t;

  // one register access held stable in the link domain
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [7:0] wdata;
  } gfr_access_t;
endpackage : gfr_pkg

//--- rtl/gfr_fifo_readout.sv
// gfr_fifo_readout: gesture dataset fifo, its status flags and the
// interrupt clear/force registers behind the serial register port.
// assumes the serial bus engine runs on link_clk and issues one access,
// then waits for acc_busy to fall before the next.
`timescale 1ns/1ps

module gfr_fifo_readout
  import gfr_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic push_valid,
  input wire gfr_dataset_t push_data,
  input wire logic motion_mode_active,
  input wire logic [7:0] fifo_threshold,
  input wire logic motion_interrupt_enable,
  input wire logic pattern_burst_event,
  input wire logic proximity_event,
  input wire logic light_event,
  output logic motion_interrupt,
  output logic [7:0] dataset_count,
  output logic int_n,
  output logic int_n_oe,
  input wire logic link_clk,
  input wire logic acc_req,
  input wire logic acc_cont,
  input wire logic [7:0] acc_addr,
  input wire logic acc_write,
  input wire logic [7:0] acc_wdata,
  output logic acc_busy,
  output logic [7:0] acc_rdata
);

  // next register address of a page access
  function automatic logic [7:0] step_addr(input logic [7:0] a);
    step_addr = (a == ADDR_EAST) ? ADDR_NORTH : 8'(a + 8'h01);
  endfunction : step_addr

  // link domain state
  gfr_access_t lnk_acc; // access held stable for the crossing
  logic lnk_tgl; // flips once per access
  logic [2:0] ack_sync; // ack toggle into the link domain
  logic ack_seen; // last ack value taken
  // main domain state
  logic [2:0] req_sync; // request toggle into the main domain
  logic req_seen; // last request value taken
  logic ack_tgl; // flips when an access is finished
  logic [7:0] rd_data; // read answer, stable until the next access
  gfr_dataset_t mem [DEPTH]; // repurposed pattern ram
  logic [4:0] wr_ptr;
  logic [4:0] rd_ptr;
  logic [5:0] count; // 0..DEPTH datasets
  logic data_valid_flag;
  logic fifo_overflow_flag;
  logic pb_pend; // pattern burst interrupt pending
  logic px_pend; // proximity interrupt pending
  logic lt_pend; // light interrupt pending
  logic force_pend; // forced interrupt pending

  // page reads continue from the last address, single reads start fresh
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lnk_acc <= '0;
      lnk_tgl <= 1'b0;
    end else if (acc_req && !acc_busy) begin
      // address walk of a page access
      lnk_acc.addr <= acc_cont ? step_addr(lnk_acc.addr) : acc_addr;
      lnk_acc.write <= acc_write;
      lnk_acc.wdata <= acc_wdata;
      lnk_tgl <= ~lnk_tgl;
    end
  end

  // ack toggle through three flops; a change counts when 2nd and 3rd agree
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      ack_sync <= 3'h0;
      ack_seen <= 1'b0;
    end else begin
      ack_sync <= {ack_sync[1:0], ack_tgl};
      if (ack_sync[2] == ack_sync[1]) begin
        ack_seen <= ack_sync[2];
      end
    end
  end

  // read answer captured once the ack is seen; rd_data is stable then
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      acc_rdata <= RST_BYTE;
    end else if (ack_sync[2] == ack_sync[1] && ack_sync[2] != ack_seen) begin
      acc_rdata <= rd_data;
    end
  end

  // busy until the ack of the last access has come back
  assign acc_busy = (lnk_tgl != ack_seen);

  // request toggle into the main domain, same three-flop filter
  logic acc_go; // one-cycle pulse: an access is to be carried out
  assign acc_go = (req_sync[2] == req_sync[1]) && (req_sync[2] != req_seen);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req_sync <= 3'h0;
      req_seen <= 1'b0;
    end else begin
      req_sync <= {req_sync[1:0], lnk_tgl};
      if (req_sync[2] == req_sync[1]) begin
        req_seen <= req_sync[2];
      end
    end
  end

  // access decode; lnk_acc has been stable for two cycles at least
  logic [7:0] a_addr;
  logic hit_fifo; // any of the four fifo byte addresses
  logic do_pop; // east byte read with data present
  logic do_push; // dataset accepted into the fifo
  logic full;
  assign a_addr = lnk_acc.addr;
  assign hit_fifo = acc_go && !lnk_acc.write && (a_addr[7:2] == 6'h3f);
  assign full = (count == 6'(DEPTH));
  assign do_pop = hit_fifo && (a_addr == ADDR_EAST) && (count != 6'h00);
  // datasets are only taken while motion mode runs
  assign do_push = push_valid && motion_mode_active && !full;

  // dataset storage; a full fifo keeps what it has
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // pointers and count; a pop frees no room for a push in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= RST_PTR;
      rd_ptr <= RST_PTR;
      count <= RST_COUNT;
    end else begin
      if (do_push) begin
        wr_ptr <= 5'(wr_ptr + 5'h01);
      end
      if (do_pop) begin
        rd_ptr <= 5'(rd_ptr + 5'h01);
      end
      count <= 6'(count + {5'h00, do_push} - {5'h00, do_pop});
    end
  end

  assign dataset_count = {2'h0, count};
  // motion interrupt: more datasets than the threshold
  assign motion_interrupt = (dataset_count > fifo_threshold);

  // status flags; set wins over clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      data_valid_flag <= 1'b0;
      fifo_overflow_flag <= 1'b0;
    end else begin
      if (motion_interrupt) begin
        data_valid_flag <= 1'b1;
      end else if (!motion_mode_active && count == 6'h00) begin
        data_valid_flag <= 1'b0;
      end
      // overflow is kept until the same idle-and-empty point
      if (push_valid && motion_mode_active && full) begin
        fifo_overflow_flag <= 1'b1;
      end else if (!motion_mode_active && count == 6'h00) begin
        fifo_overflow_flag <= 1'b0;
      end
    end
  end

  // pending sources; read or write both clear, data is ignored
  logic clr_pb;
  logic clr_px;
  logic clr_lt;
  logic clr_all;
  assign clr_all = acc_go && (a_addr == ADDR_ALL_CLR);
  assign clr_pb = clr_all || (acc_go && a_addr == ADDR_PB_CLR);
  assign clr_px = clr_all || (acc_go && a_addr == ADDR_PX_CLR);
  assign clr_lt = clr_all || (acc_go && a_addr == ADDR_LT_CLR);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pb_pend <= 1'b0;
      px_pend <= 1'b0;
      lt_pend <= 1'b0;
      force_pend <= 1'b0;
    end else begin
      pb_pend <= pattern_burst_event || (pb_pend && !clr_pb);
      px_pend <= proximity_event || (px_pend && !clr_px);
      lt_pend <= light_event || (lt_pend && !clr_lt);
      // a forced interrupt counts as a non-motion source
      force_pend <= (acc_go && a_addr == ADDR_FORCE)
                    || (force_pend && !clr_all);
    end
  end

  // open-drain pin: drive low while anything unmasked is pending
  assign int_n = 1'b0;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_n_oe <= 1'b0;
    end else begin
      int_n_oe <= pb_pend || px_pend || lt_pend || force_pend
                  || (motion_interrupt_enable && motion_interrupt);
    end
  end

  // read answer; the dataset under rd_ptr is the oldest one
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data <= RST_BYTE;
    end else if (acc_go) begin
      rd_data <= RST_BYTE;
      if (hit_fifo && count != 6'h00) begin
        case (a_addr)
          ADDR_NORTH: rd_data <= mem[rd_ptr].north;
          ADDR_SOUTH: rd_data <= mem[rd_ptr].south;
          ADDR_WEST: rd_data <= mem[rd_ptr].west;
          default: rd_data <= mem[rd_ptr].east;
        endcase
      end else if (!lnk_acc.write && a_addr == ADDR_STATUS) begin
        rd_data[STAT_OVF_BIT] <= fifo_overflow_flag;
        rd_data[STAT_VALID_BIT] <= data_valid_flag;
      end else if (!lnk_acc.write && a_addr == ADDR_COUNT) begin
        rd_data <= dataset_count;
      end
      // an empty fifo answers zero, as set above
    end
  end

  // ack back to the link once the answer is in rd_data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_tgl <= 1'b0;
    end else if (acc_go) begin
      ack_tgl <= ~ack_tgl;
    end
  end

  ovf_set_a: assert property (@(posedge mclk) disable iff (rst)
    push_valid && motion_mode_active && full |=> fifo_overflow_flag)
    else $error("overflow flag not set on dropped dataset");
  valid_set_a: assert property (@(posedge mclk) disable iff (rst)
    motion_interrupt |=> data_valid_flag)
    else $error("valid flag not set above threshold");
  valid_clr_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(data_valid_flag)
    |-> !$past(motion_mode_active) && $past(count) == 6'h00)
    else $error("valid flag cleared too early");
  pb_clear_a: assert property (@(posedge mclk) disable iff (rst)
    acc_go && a_addr == ADDR_PB_CLR && !pattern_burst_event |=> !pb_pend)
    else $error("burst interrupt not cleared");
  force_pin_a: assert property (@(posedge mclk) disable iff (rst)
    acc_go && a_addr == ADDR_FORCE |=> ##1 int_n_oe)
    else $error("forced interrupt not on pin");
  all_clear_a: assert property (@(posedge mclk) disable iff (rst)
    clr_all && !pattern_burst_event && !proximity_event && !light_event
    |=> !pb_pend && !px_pend && !lt_pend && !force_pend)
    else $error("non-motion sources not all cleared");
  full_keep_a: assert property (@(posedge mclk) disable iff (rst)
    full && !do_pop |=> count == 6'(DEPTH) && $stable(wr_ptr))
    else $error("full fifo changed by a push");
  // the pop is judged from the access itself, not from do_pop
  east_pop_a: assert property (@(posedge mclk) disable iff (rst)
    hit_fifo && a_addr == ADDR_EAST && count != 6'h00 && !do_push
    |=> count == 6'($past(count) - 6'h01)
    && rd_ptr == 5'($past(rd_ptr) + 5'h01))
    else $error("east read did not pop one dataset");
  side_nopop_a: assert property (@(posedge mclk) disable iff (rst)
    hit_fifo && a_addr != ADDR_EAST && !do_push
    |=> $stable(count) && $stable(rd_ptr))
    else $error("non-east fifo read moved the fifo");
  empty_zero_a: assert property (@(posedge mclk) disable iff (rst)
    hit_fifo && count == 6'h00 |=> rd_data == RST_BYTE)
    else $error("empty fifo read not zero");
  depth_a: assert property (@(posedge mclk) disable iff (rst)
    count <= 6'(DEPTH) && (count != 6'h00 || rd_ptr == wr_ptr))
    else $error("fifo count beyond depth");
endmodule : gfr_fifo_readout

//--- tb/gfr_host_model.sv
// gfr_host_model: serial bus controller stand-in on the register port.
// assumes the bench releases rst before the first access is issued.
`timescale 1ns/1ps
module gfr_host_model
  import gfr_pkg::*;
(
  input wire logic link_clk,
  input wire logic acc_busy,
  input wire logic [7:0] acc_rdata,
  output logic acc_req,
  output logic acc_cont,
  output logic [7:0] acc_addr,
  output logic acc_write,
  output logic [7:0] acc_wdata,
  output logic rd_done, // one link cycle: rd_data holds a read answer
  output logic [7:0] rd_data,
  output logic tmo // an access never finished
);
  // idle bus before the first access
  initial begin
    {acc_req, acc_cont, acc_write, rd_done, tmo} = '0;
    {acc_addr, acc_wdata, rd_data} = '0;
  end

  // one access, single byte or next step of a page
  // req drops at the take edge, since busy is low there and a held
  // req would be taken twice once busy falls again
  task automatic access(input logic [7:0] a, input logic c, input logic w,
                        input logic [7:0] d);
    int n;
    @(posedge link_clk);
    {acc_req, acc_cont, acc_write} <= {1'b1, c, w};
    {acc_addr, acc_wdata} <= {a, d};
    // take edge: busy is sampled low here
    @(posedge link_clk);
    acc_req <= 1'b0;
    n = 0;
    // bounded wait; the edge that samples busy low also takes the answer
    do begin
      @(posedge link_clk);
      n++;
    end while (acc_busy !== 1'b0 && n < 40);
    tmo <= (acc_busy !== 1'b0);
    {rd_done, rd_data} <= {!w, acc_rdata};
    // released fields no longer show the last value
    {acc_addr, acc_wdata} <= ~{acc_addr, acc_wdata};
    @(posedge link_clk);
    rd_done <= 1'b0;
  endtask : access
endmodule : gfr_host_model

//--- tb/gfr_fifo_readout_tb_top.sv
// gfr_fifo_readout_tb_top: self-checking bench of the fifo readout block.
// assumes gfr_host_model drives the register port on link_clk.
`timescale 1ns/1ps
module gfr_fifo_readout_tb_top
  import gfr_pkg::*;
;
  logic mclk, link_clk, rst, push_valid, motion_mode_active;
  logic motion_interrupt_enable, pattern_burst_event, proximity_event;
  logic light_event, motion_interrupt, int_n, int_n_oe, acc_req, acc_cont;
  logic acc_write, acc_busy, rd_done, tmo, exp_ovf;
  logic [7:0] fifo_threshold, dataset_count, acc_addr, acc_wdata;
  logic [7:0] acc_rdata, rd_data;
  gfr_dataset_t push_data;
  gfr_dataset_t mq[$]; // model of the fifo contents
  logic [7:0] exq[$]; // expected read answers, oldest first
  int err_count, compares, seed;

  // clocks: 50 ns main, 125 ns link with an odd phase offset
  initial begin mclk = 0; forever #25 mclk = ~mclk; end
  initial begin link_clk = 0; #17; forever #62.5 link_clk = ~link_clk; end

  gfr_fifo_readout #(.DEPTH(FIFO_DEPTH)) DUT (.mclk, .rst, .push_valid,
    .push_data, .motion_mode_active, .fifo_threshold,
    .motion_interrupt_enable, .pattern_burst_event, .proximity_event,
    .light_event, .motion_interrupt, .dataset_count, .int_n, .int_n_oe,
    .link_clk, .acc_req, .acc_cont, .acc_addr, .acc_write, .acc_wdata,
    .acc_busy, .acc_rdata);
  gfr_host_model host (.link_clk, .acc_busy, .acc_rdata, .acc_req,
    .acc_cont, .acc_addr, .acc_write, .acc_wdata, .rd_done, .rd_data, .tmo);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // result watcher: every read answer meets the oldest note, while a note is left
  always @(posedge link_clk) begin
    if (rd_done === 1'b1 && exq.size() > 0)
      check(rd_data, exq.pop_front());
  end
  // a hung access ends the run
  always @(posedge tmo) begin
    err_count++;
    print_verdict();
  end

  // note the expected byte, then read it
  task automatic rd(input logic [7:0] a, input logic c, input logic [7:0] e);
    exq.push_back(e);
    host.access(a, c, 1'b0, 8'h00);
  endtask : rd

  // back-to-back datasets; model keeps only what fits
  task automatic push(input int n);
    gfr_dataset_t d;
    repeat (n) begin
      d = $random(seed);
      @(posedge mclk);
      push_valid <= 1'b1;
      push_data <= d;
      if (mq.size() < FIFO_DEPTH) mq.push_back(d);
      else exp_ovf = 1'b1;
    end
    @(posedge mclk);
    push_valid <= 1'b0;
  endtask : push

  // one dataset; cn, cr pick page stepping for north and the rest
  task automatic rd_ds(input logic cn, input logic cr);
    gfr_dataset_t d;
    d = (mq.size() > 0) ? mq.pop_front() : '0;
    rd(ADDR_NORTH, cn, d.north);
    rd(ADDR_SOUTH, cr, d.south);
    rd(ADDR_WEST, cr, d.west);
    rd(ADDR_EAST, cr, d.east);
  endtask : rd_ds

  task automatic pulse(input logic [2:0] m);
    @(posedge mclk);
    {pattern_burst_event, proximity_event, light_event} <= m;
    @(posedge mclk);
    {pattern_burst_event, proximity_event, light_event} <= 3'h0;
  endtask : pulse

  // interrupt pin after effects have landed
  task automatic pin(input logic e);
    repeat (4) @(posedge mclk);
    check({7'h0, int_n_oe}, {7'h0, e});
  endtask : pin

  // main sequence
  initial begin
    seed = 32'hc41c862f;
    err_count = 0;
    compares = 0;
    exp_ovf = 1'b0;
    rst = 1'b1;
    {push_valid, motion_mode_active, motion_interrupt_enable} = '0;
    {pattern_burst_event, proximity_event, light_event} = '0;
    push_data = '0;
    fifo_threshold = 8'h01;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge link_clk);
    rd(ADDR_COUNT, 1'b0, 8'h00);
    rd(ADDR_STATUS, 1'b0, 8'h00);
    rd_ds(1'b0, 1'b0);
    @(posedge mclk) motion_mode_active <= 1'b1;
    push(3);
    repeat (2) @(posedge mclk);
    check({7'h0, motion_interrupt}, 8'h01);
    rd(ADDR_STATUS, 1'b0, 8'h01);
    rd(ADDR_COUNT, 1'b0, 8'h03);
    rd_ds(1'b0, 1'b0);
    rd(ADDR_COUNT, 1'b0, 8'h02);
    rd_ds(1'b0, 1'b1);
    rd_ds(1'b1, 1'b1);
    rd(ADDR_STATUS, 1'b0, 8'h01);
    rd_ds(1'b0, 1'b0);
    @(posedge mclk) motion_mode_active <= 1'b0;
    rd(ADDR_STATUS, 1'b0, 8'h00);
    // one dataset beyond capacity; the first 32 must survive
    @(posedge mclk) motion_mode_active <= 1'b1;
    push(FIFO_DEPTH + 1);
    rd(ADDR_COUNT, 1'b0, 8'(FIFO_DEPTH));
    rd(ADDR_STATUS, 1'b0, {6'h0, exp_ovf, 1'b1});
    rd_ds(1'b0, 1'b1);
    for (int i = 1; i < FIFO_DEPTH; i++) rd_ds(1'b1, 1'b1);
    // nothing new arrived while draining, so no second readout is due
    check({7'h0, motion_interrupt}, 8'h00);
    @(posedge mclk) motion_mode_active <= 1'b0;
    exp_ovf = 1'b0;
    rd(ADDR_STATUS, 1'b0, 8'h00);
    // motion interrupt masked, then unmasked onto the pin
    @(posedge mclk) motion_mode_active <= 1'b1;
    push(2);
    pin(1'b0);
    check(dataset_count, 8'h02);
    // a higher threshold holds the motion interrupt back
    @(posedge mclk) fifo_threshold <= 8'h02;
    @(posedge mclk) check({7'h0, motion_interrupt}, 8'h00);
    @(posedge mclk) fifo_threshold <= 8'h01;
    @(posedge mclk) motion_interrupt_enable <= 1'b1;
    pin(1'b1);
    @(posedge mclk) motion_interrupt_enable <= 1'b0;
    pin(1'b0);
    // each source cleared by its own register, read or write alike
    for (int i = 0; i < 3; i++) begin
      pulse(3'h4 >> i);
      pin(1'b1);
      host.access(8'(ADDR_PB_CLR + i + (i > 0)), 1'b0, 1'(i), 8'($random(seed)));
      pin(1'b0);
    end
    host.access(ADDR_FORCE, 1'b0, 1'b1, 8'($random(seed)));
    pin(1'b1);
    @(posedge mclk) motion_interrupt_enable <= 1'b1;
    pulse(3'h7);
    host.access(ADDR_ALL_CLR, 1'b0, 1'b0, 8'h00);
    pin(1'b1);
    check({7'h0, motion_interrupt}, 8'h01);
    @(posedge mclk) motion_interrupt_enable <= 1'b0;
    pin(1'b0);
    check({7'h0, int_n}, 8'h00);
    // every noted read answer must have been seen
    check(8'(exq.size()), 8'h00);
    print_verdict();
  end
endmodule : gfr_fifo_readout_tb_top
